// >>> rtl/afe_pkg.sv
// Shared constants for the battery front-end register bank and its host controller.
// Assumes one 100 MHz clock shared by both ends.
package afe_pkg;
  // ==========================================================
  // Register map of the front end (byte addresses on the link)
  localparam logic [7:0] ADDR_CONFIG_STATUS = 8'h00;
  localparam logic [7:0] ADDR_OPERATING_STATUS = 8'h01;
  localparam logic [7:0] ADDR_ANALOG_OUTPUT_SELECT = 8'h03;
  localparam logic [7:0] ADDR_SLEEP_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_FEATURE_CONFIGURATION = 8'h07;
  localparam logic [7:0] ADDR_FEATURE_WRITE_GUARD = 8'h08;
  // ==========================================================
  // Field positions
  localparam int SINGLE_FRONTEND_BIT = 5;
  localparam int WAKE_STATE_BIT = 4;
  localparam int EXT_OVERHEAT_BIT = 5;
  localparam int INT_OVERHEAT_BIT = 4;
  localparam int USER_FLAG_ONE_BIT = 7;
  localparam int USER_FLAG_ZERO_BIT = 6;
  localparam int SLEEP_BIT = 7;
  localparam int AUTO_SCAN_DISABLE_BIT = 7;
  localparam int REGULATOR_OFF_BIT = 6;
  localparam int SENSOR_SUPPLY_ON_BIT = 5;
  localparam int FORCED_RESET_BIT = 2;
  localparam int WAKE_PIN_DISABLE_BIT = 1;
  localparam int WAKE_POLARITY_BIT = 0;
  localparam int WRITE_UNLOCK_BIT = 7;
  localparam int USER_FLAG_THREE_BIT = 4;
  localparam int USER_FLAG_TWO_BIT = 3;
  // Writable bit masks; all other bits read zero, and all but the forced reset bit are reserved
  localparam logic [7:0] ANALOG_MASK = 8'hcf;
  localparam logic [7:0] SLEEP_MASK = 8'h80;
  localparam logic [7:0] FEATURE_MASK = 8'he3;
  localparam logic [7:0] GUARD_MASK = 8'h98;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Analog select codes
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_EXT_TEMP = 4'h8;
  localparam logic [3:0] SEL_INT_TEMP = 4'h9;
  // ==========================================================
  // Timing
  localparam int CLK_KHZ = 100_000;
  localparam int SCAN_PERIOD_MS = 640;
  localparam int SCAN_ON_MS = 5;
  localparam int SCAN_PERIOD_CYCLES = SCAN_PERIOD_MS * CLK_KHZ;
  localparam int SCAN_ON_CYCLES = SCAN_ON_MS * CLK_KHZ;
  // ==========================================================
  // Host controller APB registers
  localparam logic [7:0] HOST_CMD_OFFSET = 8'h00;
  localparam logic [7:0] HOST_STATUS_OFFSET = 8'h04;
  localparam int CMD_WDATA_LSB = 8;
  localparam int CMD_WRITE_BIT = 16;
  localparam int CMD_GO_BIT = 31;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_RDATA_LSB = 8;
endpackage

// >>> rtl/afe_link_if.sv
// Register access link between host controller and front-end register bank.
// Stands for the serial link at transaction level; both ends on one clock.
`timescale 1ns/10ps
interface afe_link_if;
  logic req; // Held by host until ack
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack; // One-cycle answer pulse
  logic [7:0] rdata;
  modport host (output req, output we, output addr, output wdata, input ack, input rdata);
  modport device (input req, input we, input addr, input wdata, output ack, output rdata);
endinterface

// >>> rtl/afe_register_bank.sv
// Register bank of the battery front end, serving the host over the link.
// Assumes the host holds a request until ack; analog inputs are asynchronous.
//
// Rules this block and its host follow
// (R1) Writing one acts; status one means present.
// (R2) Host writes zeros into reserved bits.
// (R3) Host never writes addresses 09H to FFH.
// (R4) Host ignores reserved bits on read.
// (R5) Reading 01H clears its status bits.
// (R6) Other status bits simply follow their condition.
// (R7) External overheat flag sticky, read-clear once gone.
// (R8) Internal overheat flag sticky, read-clear once gone.
// (R9) Feature writes only while unlock bit set.
// (R10) Sleep clears on reset, wake edge, zero write.
// (R11) Wake status bit follows pin and polarity.
// (R12) Single front-end bit fixed, never writable.
// (R13) Feature register bit layout as specified.
// (R14) Forced reset bit zeroes every writable register.
// (R15) Sleep turns regulator off, keeps analog select.
// (R16) Auto scan powers sensor 5ms per 640ms.
// (R17) Analog select decodes cells and temperatures.
// (R18) Unused locations ignore writes, read zero.
//
// Design decision made here: register access over the transaction-level link, not APB.
`timescale 1ns/10ps
module afe_register_bank
  import afe_pkg::*;
#(
  parameter int SCAN_PERIOD = SCAN_PERIOD_CYCLES,
  parameter int SCAN_ON = SCAN_ON_CYCLES,
  parameter logic SINGLE_FRONTEND = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  afe_link_if.device link,
  input wire logic wakePin,
  input wire logic extOverheat,
  input wire logic intOverheat,
  output logic [3:0] analogSelect,
  output logic [6:0] cellSelect,
  output logic extTempSelect,
  output logic intTempSelect,
  output logic [3:0] userFlags,
  output logic sleepMode,
  output logic regulatorOff,
  output logic sensorSupply,
  output logic wakePinDisabled
);

  // ==========================================================
  // Helpers
  // Mux decode: one-hot cell, then ext and int temperature
  function automatic logic [8:0] decodeSelect(input logic [3:0] code);
    logic [8:0] sel;
    sel = '0;
    if (code >= 4'h1 && code <= 4'h7) begin
      sel[code - 4'h1] = 1'b1;
    end else if (code == SEL_EXT_TEMP) begin
      sel[7] = 1'b1;
    end else if (code == SEL_INT_TEMP) begin
      sel[8] = 1'b1;
    end
    return sel; // Zero and reserved codes give no output
  endfunction

  // ==========================================================
  // Input synchronisers
  logic wakeMetaQ, wakeSyncQ, wakePrevQ;
  logic extMetaQ, extSyncQ, intMetaQ, intSyncQ;

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wakeMetaQ <= 1'b0;
      wakeSyncQ <= 1'b0;
      wakePrevQ <= 1'b0;
      extMetaQ <= 1'b0;
      extSyncQ <= 1'b0;
      intMetaQ <= 1'b0;
      intSyncQ <= 1'b0;
    end else begin
      wakeMetaQ <= wakePin;
      wakeSyncQ <= wakeMetaQ;
      wakePrevQ <= wakeSyncQ;
      extMetaQ <= extOverheat;
      extSyncQ <= extMetaQ;
      intMetaQ <= intOverheat;
      intSyncQ <= intMetaQ;
    end
  end

  // ==========================================================
  // Register state
  logic [7:0] analogQ, analogD;
  logic [7:0] featQ, featD;
  logic [7:0] guardQ, guardD;
  logic sleepQ, sleepD;
  logic extFlagQ, extFlagD, intFlagQ, intFlagD;
  logic ackQ, ackD;
  logic [7:0] rdataQ, rdataD;
  logic [8:0] muxQ, muxD;
  logic [31:0] scanCntQ, scanCntD;
  logic supplyQ, supplyD;

  logic access, wr, rd, wakeEvent, wakeState, unlocked;
  logic [7:0] readValue;

  // Access decode and wake handling
  always_comb begin
    access = link.req && !ackQ; // One access per request
    wr = access && link.we;
    rd = access && !link.we;
    unlocked = guardQ[WRITE_UNLOCK_BIT];
    // Status follows pin level per polarity
    wakeState = featQ[WAKE_POLARITY_BIT] ? wakeSyncQ : !wakeSyncQ; // see (R11)
    // Edge selected by polarity, blocked when wake pin disabled
    wakeEvent = !featQ[WAKE_PIN_DISABLE_BIT]
      && (featQ[WAKE_POLARITY_BIT] ? (wakeSyncQ && !wakePrevQ)
                                   : (!wakeSyncQ && wakePrevQ)); // see (R10)
  end

  // Read mux; reserved bits and unused locations read zero
  always_comb begin
    readValue = 8'h00; // see (R18)
    if (link.addr == ADDR_CONFIG_STATUS) begin
      readValue[SINGLE_FRONTEND_BIT] = SINGLE_FRONTEND; // see (R12)
      readValue[WAKE_STATE_BIT] = wakeState; // see (R6)
    end else if (link.addr == ADDR_OPERATING_STATUS) begin
      readValue[EXT_OVERHEAT_BIT] = extFlagQ;
      readValue[INT_OVERHEAT_BIT] = intFlagQ;
    end else if (link.addr == ADDR_ANALOG_OUTPUT_SELECT) begin
      readValue = analogQ & ANALOG_MASK;
    end else if (link.addr == ADDR_SLEEP_CONTROL) begin
      readValue[SLEEP_BIT] = sleepQ;
    end else if (link.addr == ADDR_FEATURE_CONFIGURATION) begin
      readValue = featQ & FEATURE_MASK;
    end else if (link.addr == ADDR_FEATURE_WRITE_GUARD) begin
      readValue = guardQ & GUARD_MASK;
    end
  end

  // Next register values
  always_comb begin
    analogD = analogQ;
    featD = featQ;
    guardD = guardQ;
    sleepD = sleepQ;
    ackD = access;
    rdataD = rd ? readValue : rdataQ;
    // Set beats the read-clear, and the clear waits for the condition to go
    extFlagD = extSyncQ || (extFlagQ && !(rd && link.addr == ADDR_OPERATING_STATUS)); // see (R7)
    intFlagD = intSyncQ || (intFlagQ && !(rd && link.addr == ADDR_OPERATING_STATUS)); // see (R8)
    // Ones written act; reserved bits are masked off
    if (wr && link.addr == ADDR_ANALOG_OUTPUT_SELECT) begin
      analogD = link.wdata & ANALOG_MASK; // see (R1)
    end else if (wr && link.addr == ADDR_SLEEP_CONTROL) begin
      sleepD = link.wdata[SLEEP_BIT]; // see (R10)
    end else if (wr && link.addr == ADDR_FEATURE_CONFIGURATION && unlocked) begin
      featD = link.wdata & FEATURE_MASK; // see (R9) see (R13)
    end else if (wr && link.addr == ADDR_FEATURE_WRITE_GUARD) begin
      guardD = link.wdata & GUARD_MASK;
    end
    // Wake only matters while asleep; analog select is left alone
    if (wakeEvent) begin
      sleepD = 1'b0; // see (R10) see (R15)
    end
    // Forced reset: every writable register back to zero, overheat flags take the synced condition
    if (wr && link.addr == ADDR_FEATURE_CONFIGURATION && unlocked
        && link.wdata[FORCED_RESET_BIT]) begin
      analogD = REG_RESET; // see (R14)
      featD = REG_RESET;
      guardD = REG_RESET;
      sleepD = 1'b0;
      extFlagD = extSyncQ;
      intFlagD = intSyncQ;
    end
    muxD = decodeSelect(analogD[3:0]); // see (R17)
  end

  // Automatic sensor scan and sensor supply
  always_comb begin
    scanCntD = scanCntQ;
    if (featQ[AUTO_SCAN_DISABLE_BIT]) begin
      scanCntD = '0;
    end else if (scanCntQ >= 32'(SCAN_PERIOD - 1)) begin
      scanCntD = '0;
    end else begin
      scanCntD = scanCntQ + 32'd1;
    end
    // Scan window at the start of each period; the manual enable overrides
    supplyD = featD[SENSOR_SUPPLY_ON_BIT]
      || (!featD[AUTO_SCAN_DISABLE_BIT] && scanCntD < 32'(SCAN_ON)); // see (R16)
  end

  // Register everything; synchronous reset clears to zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      analogQ <= REG_RESET;
      featQ <= REG_RESET;
      guardQ <= REG_RESET;
      sleepQ <= 1'b0; // see (R10)
      extFlagQ <= 1'b0;
      intFlagQ <= 1'b0;
      ackQ <= 1'b0;
      rdataQ <= 8'h00;
      muxQ <= '0;
      scanCntQ <= '0;
      supplyQ <= 1'b0;
    end else begin
      analogQ <= analogD;
      featQ <= featD;
      guardQ <= guardD;
      sleepQ <= sleepD;
      extFlagQ <= extFlagD;
      intFlagQ <= intFlagD;
      ackQ <= ackD;
      rdataQ <= rdataD;
      muxQ <= muxD;
      scanCntQ <= scanCntD;
      supplyQ <= supplyD;
    end
  end

  // ==========================================================
  // Outputs, all from flops
  assign link.ack = ackQ;
  assign link.rdata = rdataQ;
  assign analogSelect = analogQ[3:0];
  assign cellSelect = muxQ[6:0];
  assign extTempSelect = muxQ[7];
  assign intTempSelect = muxQ[8];
  assign userFlags = {guardQ[USER_FLAG_THREE_BIT], guardQ[USER_FLAG_TWO_BIT],
                      analogQ[USER_FLAG_ONE_BIT], analogQ[USER_FLAG_ZERO_BIT]};
  assign sleepMode = sleepQ; // see (R15)
  // Sleep or the disable bit turns the internal regulator off
  assign regulatorOff = sleepQ || featQ[REGULATOR_OFF_BIT]; // see (R15)
  assign sensorSupply = supplyQ;
  assign wakePinDisabled = featQ[WAKE_PIN_DISABLE_BIT];

endmodule // afe_register_bank

// >>> rtl/afe_host_ctrl.sv
// Host end: APB slave that turns software commands into link accesses.
// Assumes the register bank on the link answers with a one-cycle ack.
`timescale 1ns/10ps
module afe_host_ctrl
  import afe_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  afe_link_if.host link
);

  typedef enum logic {IDLE, WAIT} host_state_t;

  host_state_t stateQ, stateD;
  logic [7:0] addrQ, addrD, wdataQ, wdataD, rdataQ, rdataD;
  logic weQ, weD, doneQ, doneD;
  logic apbWrite, apbRead, goWrite;

  // ==========================================================
  // Command state machine
  // Commands arriving while busy are dropped so a held request never changes
  always_comb begin
    apbWrite = psel && penable && pwrite;
    apbRead = psel && penable && !pwrite;
    goWrite = apbWrite && paddr == HOST_CMD_OFFSET && pwdata[CMD_GO_BIT];
    stateD = stateQ;
    addrD = addrQ;
    wdataD = wdataQ;
    weD = weQ;
    rdataD = rdataQ;
    doneD = doneQ;
    case (stateQ)
      IDLE: begin
        if (goWrite) begin
          addrD = pwdata[7:0]; // Host must avoid 09H and up, see (R3)
          wdataD = pwdata[CMD_WDATA_LSB +: 8]; // Reserved bits zero, see (R2)
          weD = pwdata[CMD_WRITE_BIT];
          doneD = 1'b0;
          stateD = WAIT;
        end
      end
      WAIT: begin
        if (link.ack) begin
          rdataD = link.rdata;
          doneD = 1'b1;
          stateD = IDLE;
        end
      end
      default: stateD = IDLE;
    endcase
  end

  // Register state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateQ <= IDLE;
      addrQ <= 8'h00;
      wdataQ <= 8'h00;
      weQ <= 1'b0;
      rdataQ <= 8'h00;
      doneQ <= 1'b0;
    end else begin
      stateQ <= stateD;
      addrQ <= addrD;
      wdataQ <= wdataD;
      weQ <= weD;
      rdataQ <= rdataD;
      doneQ <= doneD;
    end
  end

  // ==========================================================
  // Link and APB outputs
  assign link.req = stateQ == WAIT;
  assign link.we = weQ;
  assign link.addr = addrQ;
  assign link.wdata = wdataQ;
  assign pready = 1'b1;

  // Read data; software ignores reserved bits of rdata, see (R4)
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr == HOST_CMD_OFFSET) begin
      prdata[CMD_WRITE_BIT] = weQ;
      prdata[CMD_WDATA_LSB +: 8] = wdataQ;
      prdata[7:0] = addrQ;
    end else if (paddr == HOST_STATUS_OFFSET) begin
      prdata[STAT_BUSY_BIT] = stateQ == WAIT;
      prdata[STAT_DONE_BIT] = doneQ;
      prdata[STAT_RDATA_LSB +: 8] = rdataQ;
    end else begin
      pslverr = psel && penable;
    end
    if (!apbRead) begin
      prdata = 32'h0000_0000;
    end
  end

endmodule // afe_host_ctrl

// >>> test/afe_link_properties.sv
// Link checker: handshake and read-data rules seen on the link wires.
// Assumes one clock and the synchronous active-low reset of both ends.
`timescale 1ns/10ps
module afe_link_properties
  import afe_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  // ==========================================
  // Helpers
  logic rd;
  logic [7:0] rsvd;
  // Bits that must read zero; the forced reset bit never reads back
  always_comb begin
    case (addr)
      8'h00, 8'h01: rsvd = 8'hcf;
      8'h03: rsvd = ~ANALOG_MASK;
      8'h04: rsvd = ~SLEEP_MASK;
      8'h07: rsvd = ~FEATURE_MASK;
      8'h08: rsvd = ~GUARD_MASK;
      default: rsvd = 8'hff;
    endcase
  end
  assign rd = ack && !we;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Properties
  property p_ack_turn; req && !ack |=> ack; endproperty
  a_ack_turn: assert property (p_ack_turn) else $error("request not answered");
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause; ack |-> $past(req) && !$past(ack); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_req_hold; req && !ack |=> req && $stable({we, addr, wdata}); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed early");
  property p_req_drop; ack |=> !req; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
  property p_rsvd_zero; rd |-> (rdata & rsvd) == 8'h00; endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read set");
  property p_single_fe; rd && addr == ADDR_CONFIG_STATUS |-> rdata[SINGLE_FRONTEND_BIT]; endproperty
  a_single_fe: assert property (p_single_fe) else $error("fixed bit not set");
  property p_rdata_hold; !ack |-> $stable(rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  // Main scenarios reached
  c_flags: cover property (rd && addr == ADDR_OPERATING_STATUS && rdata != 8'h00);
  c_feature: cover property (ack && we && addr == ADDR_FEATURE_CONFIGURATION);
  c_high: cover property (rd && addr > ADDR_FEATURE_WRITE_GUARD);
endmodule // afe_link_properties

// >>> test/battery_afe_register_bank_tb_top.sv
// Bench: software over APB drives the host end, which reaches the bank over the link.
// Assumes shortened scan counts; the link checker sits beside the interface.
`timescale 1ns/10ps
module battery_afe_register_bank_tb_top
  import afe_pkg::*;
;
  localparam int PER = 64;
  localparam int ON = 5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, prdCap;
  logic pslverr, errCap;
  logic pready, wakePin = 1'b0, extOverheat = 1'b0, intOverheat = 1'b0;
  logic [3:0] analogSelect, userFlags;
  logic [6:0] cellSelect;
  logic extTemp, intTemp, sleepMode, regOff, sensorSupply, wakeOff;
  logic [7:0] rnd = 8'h61;
  int n_fail = 0;
  int check_count = 0;
  int cycleCount = 0;
  afe_link_if link();
  afe_host_ctrl afe_host_ctrl_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link.host));
  afe_register_bank #(.SCAN_PERIOD(PER), .SCAN_ON(ON)) afe_register_bank_inst (.clk(clk),
    .rst_n(rst_n), .link(link.device), .wakePin(wakePin), .extOverheat(extOverheat),
    .intOverheat(intOverheat), .analogSelect(analogSelect), .cellSelect(cellSelect),
    .extTempSelect(extTemp), .intTempSelect(intTemp), .userFlags(userFlags),
    .sleepMode(sleepMode), .regulatorOff(regOff), .sensorSupply(sensorSupply),
    .wakePinDisabled(wakeOff));
  afe_link_properties afe_link_properties_inst (.clk(clk), .rst_n(rst_n), .req(link.req),
    .we(link.we), .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
  // ==========================================
  // Clock, read data taken at the answering edge, hang limit
  always #5 clk = ~clk;
  always @(posedge clk) prdCap <= prdata;
  always @(posedge clk) errCap <= pslverr;
  always @(posedge clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  // ==========================================
  // Expectations and stimulus helpers
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Select outputs as {internal, external, cells 7..1}
  function automatic logic [8:0] dec(input logic [3:0] c);
    dec = 9'h000;
    if (c >= 4'h1 && c <= 4'h7) dec[c - 1] = 1'b1;
    dec[7] = (c == SEL_EXT_TEMP);
    dec[8] = (c == SEL_INT_TEMP);
  endfunction
  // Reserved bits are written as zero at 04H and 08H; 02H fully reserved; 05H and 06H take the whole random byte
  function automatic logic [7:0] wm(input logic [7:0] a);
    case (a)
      8'h04: wm = SLEEP_MASK;
      8'h08: wm = GUARD_MASK;
      8'h02: wm = 8'h00;
      default: wm = 8'hff;
    endcase
  endfunction
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the answer waits only on pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
    q = prdCap;
  endtask
  // One link access: command, then poll status until done
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    logic [31:0] s;
    apb(1'b1, HOST_CMD_OFFSET, {1'b1, 14'h0000, wr, d, a}, s);
    // Only the bench timeout ends a wait that never finishes
    do begin
      apb(1'b0, HOST_STATUS_OFFSET, 32'h0, s);
    end while (s[STAT_BUSY_BIT] || !s[STAT_DONE_BIT]);
    q = s[STAT_RDATA_LSB +: 8];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    chk(9'(q), 9'(e));
  endtask
  task automatic complete_run();
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================
  // Main sequence
  // Read sweep, and random write targets that all stay below 09H
  logic [7:0] zl[10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'hff};
  logic [7:0] wa[5] = '{8'h04, 8'h05, 8'h06, 8'h08, 8'h02};
  initial begin
    logic [7:0] a, d;
    logic [31:0] p;
    int n;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rchk(ADDR_CONFIG_STATUS, 8'h30);
    foreach (zl[i]) rchk(zl[i], 8'h00);
    // Unmapped host offset answers with an error, a mapped one does not
    apb(1'b0, 8'h08, 32'h0, p);
    chk(9'(errCap), 9'h001);
    apb(1'b0, HOST_STATUS_OFFSET, 32'h0, p);
    chk(9'(errCap), 9'h000);
    // Every select code, with random flags and random other registers
    for (int i = 0; i < 16; i++) begin
      rnd = nxt(rnd);
      d = (rnd & 8'hc0) | 8'(i);
      wr(ADDR_ANALOG_OUTPUT_SELECT, d);
      chk({intTemp, extTemp, cellSelect}, dec(d[3:0]));
      chk(9'(analogSelect), 9'(i));
      rchk(ADDR_ANALOG_OUTPUT_SELECT, d);
      a = wa[i % 5];
      rnd = nxt(rnd);
      wr(a, rnd & wm(a));
      rchk(a, (a == 8'h05 || a == 8'h06) ? 8'h00 : rnd & wm(a));
      chk(9'(userFlags[1:0]), 9'(d[7:6]));
    end
    // Feature register locked, then unlocked
    wr(ADDR_FEATURE_WRITE_GUARD, 8'h00);
    wr(ADDR_FEATURE_CONFIGURATION, 8'h42);
    rchk(ADDR_FEATURE_CONFIGURATION, 8'h00);
    wr(ADDR_FEATURE_WRITE_GUARD, 8'h98);
    chk(9'(userFlags[3:2]), 9'h003);
    wr(ADDR_FEATURE_CONFIGURATION, 8'he3);
    rchk(ADDR_FEATURE_CONFIGURATION, 8'he3);
    chk(9'({regOff, wakeOff, sensorSupply}), 9'h007);
    // Sleep and wake on both polarities
    wr(ADDR_FEATURE_CONFIGURATION, 8'h01);
    rchk(ADDR_CONFIG_STATUS, 8'h20);
    wr(ADDR_ANALOG_OUTPUT_SELECT, 8'h45);
    wr(ADDR_SLEEP_CONTROL, 8'h80);
    chk(9'({sleepMode, regOff}), 9'h003);
    @(posedge clk);
    wakePin <= 1'b1;
    repeat (6) @(posedge clk);
    chk(9'(sleepMode), 9'h000);
    rchk(ADDR_ANALOG_OUTPUT_SELECT, 8'h45);
    rchk(ADDR_CONFIG_STATUS, 8'h30);
    wr(ADDR_SLEEP_CONTROL, 8'h80);
    wr(ADDR_FEATURE_CONFIGURATION, 8'h00);
    rchk(ADDR_CONFIG_STATUS, 8'h20);
    chk(9'(sleepMode), 9'h001);
    @(posedge clk);
    wakePin <= 1'b0;
    repeat (6) @(posedge clk);
    chk(9'(sleepMode), 9'h000);
    // Disabled wake pin must not end sleep; only a zero write does
    wr(ADDR_FEATURE_CONFIGURATION, 8'h03);
    wr(ADDR_SLEEP_CONTROL, 8'h80);
    @(posedge clk);
    wakePin <= 1'b1;
    repeat (6) @(posedge clk);
    chk(9'(sleepMode), 9'h001);
    wr(ADDR_SLEEP_CONTROL, 8'h00);
    chk(9'(sleepMode), 9'h000);
    @(posedge clk);
    wakePin <= 1'b0;
    // Overheat flags: sticky until read once the cause is gone
    extOverheat <= 1'b1;
    intOverheat <= 1'b1;
    repeat (4) @(posedge clk);
    extOverheat <= 1'b0;
    rchk(ADDR_OPERATING_STATUS, 8'h30);
    rchk(ADDR_OPERATING_STATUS, 8'h10);
    @(posedge clk);
    intOverheat <= 1'b0;
    rchk(ADDR_OPERATING_STATUS, 8'h10);
    rchk(ADDR_OPERATING_STATUS, 8'h00);
    // Forced reset clears every writable register
    wr(ADDR_ANALOG_OUTPUT_SELECT, 8'hc5);
    wr(ADDR_FEATURE_CONFIGURATION, 8'h04);
    for (int i = 2; i < 8; i++) rchk(zl[i], 8'h00);
    chk(9'(userFlags), 9'h000);
    // Sensor supply windows, scan on and then off
    for (int k = 0; k < 2; k++) begin
      n = 0;
      repeat (2 * PER) begin
        @(negedge clk);
        n += int'(sensorSupply);
      end
      chk(9'(n), 9'((1 - k) * 2 * ON));
      wr(ADDR_FEATURE_WRITE_GUARD, 8'h80);
      wr(ADDR_FEATURE_CONFIGURATION, 8'h80);
    end
    complete_run();
  end
endmodule // battery_afe_register_bank_tb_top
